// ===== term_decoder.v
// Decoder of the drive's multifunction digital input terminals.
// Assumes terminal pins asynchronous to CLK_SYS and an APB master.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "term_decoder_defs.vh"

module term_decoder #(
    parameter NUM_TERM = 8,
    parameter REF_W    = 16
) (
    input  wire                CLK_SYS,
    input  wire                RST,
    input  wire [NUM_TERM-1:0] TERM_IN,
    input  wire                PSEL,
    input  wire                PENABLE,
    input  wire                PWRITE,
    input  wire [7:0]          PADDR,
    input  wire [31:0]         PWDATA,
    output reg  [31:0]         PRDATA,
    output reg                 PREADY,
    output reg                 PSLVERR,
    output reg                 DC_BRAKE_NOW,
    output reg                 FAULT_STROBE,
    output reg  [7:0]          FAULT_CODE,
    output reg  [2:0]          FAULT_ACTION,
    output reg                 FAULT_STOP,
    output reg                 FREQ_HOLD,
    output reg                 PID_REVERSE,
    output reg                 PANEL_STOP,
    output reg  [1:0]          CMD_SOURCE,
    output reg                 PID_INT_FREEZE,
    output reg                 MAIN_PRESET,
    output reg                 AUX_PRESET,
    output reg  [1:0]          MOTOR_SEL,
    output reg                 PID_GAIN_SEL,
    output reg                 TORQUE_MODE,
    output reg                 EMERG_STOP,
    output reg                 DECEL_STOP,
    output reg                 DECEL_DC_BRAKE,
    output reg                 RUN_TIME_CLEAR,
    output reg  [REF_W-1:0]    MREF_VALUE,
    output reg  [15:0]         MREF_FREQ,
    output reg  [1:0]          ACCDEC_SEL
);

    // -----------------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------------
    // Terminal path
    reg  [NUM_TERM-1:0] sync1_reg;
    reg  [NUM_TERM-1:0] sync2_reg;
    reg  [5:0]          func_reg [0:NUM_TERM-1];
    reg  [REF_W-1:0]    ref_reg  [0:15];
    reg  [31:0]         config_reg;
    reg  [15:0]         max_freq_reg;
    reg  [63:0]         lvl_prev_reg;
    reg  [63:0]         lvl;
    wire [63:0]         rise;
    // Register bus decode
    reg  [31:0]         rd_next;
    reg                 err_next;
    wire                setup;
    wire                wr_acc;
    // Derived selectors
    wire [1:0]          src_base;
    reg  [1:0]          src_next;
    wire [3:0]          mref_idx;
    wire [1:0]          acc_idx;
    wire [31:0]         freq_prod;
    wire [31:0]         freq_scaled;
    wire                is_ref;
    wire [3:0]          ref_sel;
    integer             t;
    integer             k;
    integer             w;          // Write-side index; k belongs to the read mux

    // -----------------------------------------------------------------
    // Input synchronisers
    // -----------------------------------------------------------------
    // two-stage sampling
    // Pins are asynchronous; only the second stage is used below.
    // Reset matches open contacts, so no false edge follows reset.
    // Each bit has its own pair of stages.
    genvar g;
    generate
        for (g = 0; g < NUM_TERM; g = g + 1) begin : g_sync
            always @(posedge CLK_SYS or posedge RST) begin
                if (RST) begin
                    sync1_reg[g] <= 1'b0;
                    sync2_reg[g] <= 1'b0;
                end else begin
                    sync1_reg[g] <= TERM_IN[g];
                    sync2_reg[g] <= sync1_reg[g];
                end
            end
        end
    endgenerate

    // -----------------------------------------------------------------
    // Function levels and edges
    // -----------------------------------------------------------------
    // Several terminals on one code are ORed together
    // Code 0 has no meaning here and collects unused terminals
    always @* begin
        lvl = 64'h0;
        for (t = 0; t < NUM_TERM; t = t + 1) begin
            lvl[func_reg[t]] = lvl[func_reg[t]] | sync2_reg[t];
        end
    end

    // Previous levels for edge detection
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            lvl_prev_reg <= 64'h0;
        end else begin
            lvl_prev_reg <= lvl;
        end
    end

    // A code written while its pin is on fires once; set codes
    // with contacts open to avoid a spurious action.
    // rising edge detect
    assign rise = lvl & ~lvl_prev_reg;

    // -----------------------------------------------------------------
    // APB slave
    // -----------------------------------------------------------------
    // No wait states: ready follows the setup cycle by one edge.
    // Refused writes are dropped by the error term of the gate.
    assign setup   = PSEL & ~PENABLE;
    assign wr_acc  = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;
    assign is_ref  = (PADDR >= `OFS_REF_BASE) && (PADDR <= `OFS_REF_LAST)
                     && (PADDR[1:0] == 2'h0);
    assign ref_sel = PADDR[5:2];

    // Read mux, evaluated in the setup cycle
    // Writes read back zero; write data never reaches PRDATA
    always @* begin
        rd_next  = 32'h0;
        err_next = 1'b0;
        if (is_ref) begin
            rd_next[REF_W-1:0] = ref_reg[ref_sel];
        end else begin
            case (PADDR)
                `OFS_FUNC_LO, `OFS_FUNC_HI: begin
                    for (k = 0; k < 4; k = k + 1) begin
                        if ((k + (PADDR[2] ? 4 : 0)) < NUM_TERM) begin
                            rd_next[8*k +: 6] = func_reg[k + (PADDR[2] ? 4 : 0)];
                        end
                    end
                end
                `OFS_CONFIG:   rd_next = config_reg;
                `OFS_MAX_FREQ: rd_next[15:0] = max_freq_reg;
                `OFS_STATUS: begin
                    rd_next[NUM_TERM-1:0] = sync2_reg;
                    rd_next[9:8]          = CMD_SOURCE;
                    rd_next[11:10]        = MOTOR_SEL;
                    rd_next[13:12]        = ACCDEC_SEL;
                    rd_next[23:16]        = FAULT_CODE;
                end
                `OFS_ACTIVE:   rd_next[18:0] = lvl[50:32];
                default:       err_next = 1'b1;
            endcase
        end
    end

    // One wait-free access phase; status and active are read-only
    // Error flag clears after its one cycle with ready
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0;
        end else begin
            PREADY <= setup;
            if (setup) begin
                PRDATA  <= PWRITE ? 32'h0 : rd_next;
                PSLVERR <= err_next | (PWRITE && ((PADDR == `OFS_STATUS)
                           || (PADDR == `OFS_ACTIVE)));
            end else if (PREADY) begin
                PSLVERR <= 1'b0;
            end
        end
    end

    // Register writes at the access edge
    // Upper two bits of each function byte are ignored
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            config_reg   <= `CONFIG_RESET;
            max_freq_reg <= `MAX_FREQ_RESET;
            for (w = 0; w < NUM_TERM; w = w + 1) begin
                func_reg[w] <= 6'h00;
            end
            for (w = 0; w < 16; w = w + 1) begin
                ref_reg[w] <= {REF_W{1'b0}};
            end
        end else if (wr_acc) begin
            if (is_ref) begin
                ref_reg[ref_sel] <= PWDATA[REF_W-1:0];
            end else if (PADDR == `OFS_CONFIG) begin
                config_reg <= {23'h0, PWDATA[8:0]};
            end else if (PADDR == `OFS_MAX_FREQ) begin
                max_freq_reg <= PWDATA[15:0];
            end else begin
                for (w = 0; w < 4; w = w + 1) begin
                    if ((w + (PADDR[2] ? 4 : 0)) < NUM_TERM) begin
                        func_reg[w + (PADDR[2] ? 4 : 0)] <= PWDATA[8*w +: 6];
                    end
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // Command source and multi-reference arithmetic
    // -----------------------------------------------------------------
    // Reserved code 3 falls back to panel, keeping the output legal
    assign src_base = (config_reg[`CFG_SRC_LO +: 2] == 2'h3) ? `SRC_PANEL
                      : config_reg[`CFG_SRC_LO +: 2];

    // terminal/comm swap
    // Panel mode is not swapped by this code.
    // The panel stop gate uses this effective source too.
    always @* begin
        src_next = src_base;
        if (lvl[`FN_SRC_SW2]) begin
            if (src_base == `SRC_TERMINAL) begin
                src_next = `SRC_COMM;
            end else if (src_base == `SRC_COMM) begin
                src_next = `SRC_TERMINAL;
            end
        end
    end

    // Index bits come straight from the function levels
    // four-bit reference index
    assign mref_idx = {lvl[`FN_MREF0+3], lvl[`FN_MREF0+2],
                       lvl[`FN_MREF0+1], lvl[`FN_MREF0]};
    assign acc_idx  = {lvl[`FN_ACC0+1], lvl[`FN_ACC0]};

    // 100 % maps to maximum
    // Divider is wide but static; values settle in one cycle.
    // Two 16-bit factors fit 32 bits, so nothing is lost.
    assign freq_prod   = ref_reg[mref_idx] * max_freq_reg;
    assign freq_scaled = freq_prod / `REF_FULL_SCALE;

    // -----------------------------------------------------------------
    // Level outputs
    // -----------------------------------------------------------------
    // Levels follow the pins three edges late; nothing is latched
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            FREQ_HOLD      <= 1'b0;
            PID_REVERSE    <= 1'b0;
            CMD_SOURCE     <= `SRC_PANEL;
            PID_INT_FREEZE <= 1'b0;
            MAIN_PRESET    <= 1'b0;
            AUX_PRESET     <= 1'b0;
            MOTOR_SEL      <= 2'h0;
            PID_GAIN_SEL   <= 1'b0;
            TORQUE_MODE    <= 1'b0;
            MREF_VALUE     <= {REF_W{1'b0}};
            MREF_FREQ      <= 16'h0;
            ACCDEC_SEL     <= 2'h0;
            FAULT_ACTION   <= 3'h0;
        end else begin
            FREQ_HOLD      <= lvl[`FN_FREQ_HOLD];
            PID_REVERSE    <= config_reg[`CFG_PID_DIR] ^ lvl[`FN_PID_REV];
            CMD_SOURCE     <= src_next;
            PID_INT_FREEZE <= lvl[`FN_PID_INT];
            MAIN_PRESET    <= lvl[`FN_MAIN_PRE];
            AUX_PRESET     <= lvl[`FN_AUX_PRE];
            MOTOR_SEL      <= {lvl[`FN_MOTOR0+1], lvl[`FN_MOTOR0]};
            PID_GAIN_SEL   <= config_reg[`CFG_PID_SW] & lvl[`FN_PID_SET];
            TORQUE_MODE    <= config_reg[`CFG_MODE] ^ lvl[`FN_MODE_SW];
            MREF_VALUE     <= ref_reg[mref_idx];
            MREF_FREQ      <= (freq_scaled > {16'h0, max_freq_reg}) ?
                              max_freq_reg : freq_scaled[15:0];
            ACCDEC_SEL     <= lvl[`FN_STOP2] ? `ACCDEC_SET4 : acc_idx;
            FAULT_ACTION   <= config_reg[`CFG_ACT_LO +: 3];
        end
    end

    // -----------------------------------------------------------------
    // Event outputs, one-cycle pulses
    // -----------------------------------------------------------------
    // A held level pulses once; the pin must drop to fire again
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            DC_BRAKE_NOW   <= 1'b0;
            FAULT_STOP     <= 1'b0;
            PANEL_STOP     <= 1'b0;
            EMERG_STOP     <= 1'b0;
            DECEL_STOP     <= 1'b0;
            DECEL_DC_BRAKE <= 1'b0;
            RUN_TIME_CLEAR <= 1'b0;
        end else begin
            DC_BRAKE_NOW   <= rise[`FN_DC_NOW];
            FAULT_STOP     <= rise[`FN_EXT_FAULT];
            PANEL_STOP     <= rise[`FN_STOP1] & (src_next == `SRC_PANEL);
            EMERG_STOP     <= rise[`FN_ESTOP];
            DECEL_STOP     <= rise[`FN_STOP2];
            DECEL_DC_BRAKE <= rise[`FN_DC_DECEL];
            RUN_TIME_CLEAR <= rise[`FN_RT_CLR] & config_reg[`CFG_RT_EN];
        end
    end

    // -----------------------------------------------------------------
    // Fault reporting
    // -----------------------------------------------------------------
    // Code stays until the next fault; external fault has priority.
    // Faults on one edge share a single strobe and report one code.
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            FAULT_STROBE <= 1'b0;
            FAULT_CODE   <= `FAULT_NONE;
        end else begin
            FAULT_STROBE <= rise[`FN_EXT_FAULT] | rise[`FN_USER1]
                            | rise[`FN_USER2];
            if (rise[`FN_EXT_FAULT]) begin
                FAULT_CODE <= `EXT_FAULT_CODE;
            end else if (rise[`FN_USER1]) begin
                FAULT_CODE <= `USER_FAULT1_CODE;
            end else if (rise[`FN_USER2]) begin
                FAULT_CODE <= `USER_FAULT2_CODE;
            end
        end
    end

endmodule // term_decoder

// ===== term_decoder_defs.vh
// Constants for the input terminal function decoder.
// Assumes a 32-bit APB slave; offsets are byte addresses.
`ifndef TERM_DECODER_DEFS_VH
`define TERM_DECODER_DEFS_VH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define OFS_FUNC_LO      8'h00
`define OFS_FUNC_HI      8'h04
`define OFS_CONFIG       8'h08
`define OFS_MAX_FREQ     8'h0c
`define OFS_STATUS       8'h10
`define OFS_ACTIVE       8'h14
`define OFS_REF_BASE     8'h40
`define OFS_REF_LAST     8'h7c

// -----------------------------------------------------------------
// Config field positions and reset values
// -----------------------------------------------------------------
`define CFG_PID_DIR      0
`define CFG_PID_SW       1
`define CFG_MODE         2
`define CFG_SRC_LO       3
`define CFG_RT_EN        5
`define CFG_ACT_LO       6
`define CONFIG_RESET     32'h0000_0008
`define MAX_FREQ_RESET   16'h1388

// -----------------------------------------------------------------
// Command sources and fault codes
// -----------------------------------------------------------------
`define SRC_PANEL        2'h0
`define SRC_TERMINAL     2'h1
`define SRC_COMM         2'h2
`define FAULT_NONE       8'h00
`define EXT_FAULT_CODE   8'h0f
`define USER_FAULT1_CODE 8'h1b
`define USER_FAULT2_CODE 8'h1c

// -----------------------------------------------------------------
// Terminal function codes
// -----------------------------------------------------------------
`define FN_MREF0         12
`define FN_ACC0          16
`define FN_DC_NOW        32
`define FN_EXT_FAULT     33
`define FN_FREQ_HOLD     34
`define FN_PID_REV       35
`define FN_STOP1         36
`define FN_SRC_SW2       37
`define FN_PID_INT       38
`define FN_MAIN_PRE      39
`define FN_AUX_PRE       40
`define FN_MOTOR0        41
`define FN_PID_SET       43
`define FN_USER1         44
`define FN_USER2         45
`define FN_MODE_SW       46
`define FN_ESTOP         47
`define FN_STOP2         48
`define FN_DC_DECEL      49
`define FN_RT_CLR        50

// Full scale of a stored reference: 1000 means 100.0 %
`define REF_FULL_SCALE   32'd1000
`define ACCDEC_SET4      2'h3

`endif

// ===== term_switches.sv
// Model of the contacts wired to the decoder's input terminals.
// Assumes the bench asks for a contact pattern just after a clock edge.
`timescale 1ns/1ps

module term_switches (
    input  wire logic       clk,
    input  wire logic [7:0] want,
    output logic      [7:0] pins
);
    // No bounce, traded away for size; pins settle at the first edge, under reset
    always @(posedge clk) begin
        pins <= want;
    end
endmodule // term_switches

// ===== term_decoder_assertions.sv
// Port checker for the input terminal decoder.
// Assumes binding at the decoder top; RST is asynchronous, high.
`timescale 1ns/1ps
`include "term_decoder_defs.vh"

module term_decoder_assertions #(
    parameter NUM_TERM = 8,
    parameter REF_W    = 16
) (
    input wire logic        CLK_SYS,
    input wire logic        RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic [31:0] PRDATA,
    input wire logic        DC_BRAKE_NOW,
    input wire logic        FAULT_STROBE,
    input wire logic [7:0]  FAULT_CODE,
    input wire logic        FAULT_STOP,
    input wire logic        PANEL_STOP,
    input wire logic [1:0]  CMD_SOURCE,
    input wire logic        EMERG_STOP,
    input wire logic        DECEL_STOP,
    input wire logic        DECEL_DC_BRAKE,
    input wire logic        RUN_TIME_CLEAR,
    input wire logic [1:0]  ACCDEC_SEL
);
    // ------------------------------------------------------------
    // Sequences and properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    // Setup phase, then a ready that stands one cycle
    sequence apb_setup;
        PSEL && !PENABLE;
    endsequence
    sequence ready_once;
        PREADY ##1 !PREADY;
    endsequence
    // A pulse never lasts two cycles: the level must drop to re-trigger
    sequence one_shot(sig);
        sig ##1 !sig;
    endsequence

    a_apb_ready_next: assert property (apb_setup |=> ready_once)
        else $error("ready did not follow setup for one cycle");
    a_apb_err_data: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
        else $error("error answer without ready or with data");
    a_dc_brake_pulse: assert property (DC_BRAKE_NOW |-> one_shot(DC_BRAKE_NOW))
        else $error("braking pulse too long");
    a_ext_fault_code: assert property (FAULT_STOP |->
        FAULT_STROBE && FAULT_CODE == `EXT_FAULT_CODE)
        else $error("external fault stop without its code");
    a_panel_stop_src: assert property (PANEL_STOP |-> CMD_SOURCE == `SRC_PANEL)
        else $error("panel stop while source is not panel");
    a_cmd_src_legal: assert property (CMD_SOURCE != 2'h3)
        else $error("command source out of range");
    a_fault_code_valid: assert property (FAULT_STROBE |->
        FAULT_CODE inside {`EXT_FAULT_CODE, `USER_FAULT1_CODE, `USER_FAULT2_CODE})
        else $error("fault strobe with unknown code");
    a_fault_code_hold: assert property (!FAULT_STROBE |-> $stable(FAULT_CODE))
        else $error("fault code moved without a strobe");
    a_estop_pulse_once: assert property (EMERG_STOP |-> one_shot(EMERG_STOP))
        else $error("emergency stop pulse too long");
    a_stop_set_four: assert property (DECEL_STOP |-> ACCDEC_SEL == `ACCDEC_SET4)
        else $error("stop without time set four");
    a_decel_dc_pulse: assert property (DECEL_DC_BRAKE |=> !DECEL_DC_BRAKE)
        else $error("decel braking pulse too long");
    a_rt_clear_pulse: assert property (RUN_TIME_CLEAR |-> one_shot(RUN_TIME_CLEAR))
        else $error("running time clear pulse too long");
endmodule // term_decoder_assertions

bind term_decoder term_decoder_assertions #(.NUM_TERM(NUM_TERM), .REF_W(REF_W)) u_chk (
    .CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PRDATA(PRDATA), .DC_BRAKE_NOW(DC_BRAKE_NOW),
    .FAULT_STROBE(FAULT_STROBE), .FAULT_CODE(FAULT_CODE), .FAULT_STOP(FAULT_STOP),
    .PANEL_STOP(PANEL_STOP), .CMD_SOURCE(CMD_SOURCE), .EMERG_STOP(EMERG_STOP),
    .DECEL_STOP(DECEL_STOP), .DECEL_DC_BRAKE(DECEL_DC_BRAKE),
    .RUN_TIME_CLEAR(RUN_TIME_CLEAR), .ACCDEC_SEL(ACCDEC_SEL));

// ===== term_decoder_tb.sv
// Self-checking bench for the input terminal decoder.
// Assumes the decoder, its defines, the switch model and the bound checker.
`timescale 1ns/1ps
`include "term_decoder_defs.vh"

`define CHK(nm, ex, gt) begin total_checks = total_checks + 1; if ((gt) !== (ex)) begin \
    err_count = err_count + 1; $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end

module term_decoder_tb;
    logic        clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, want = 8'h00, pins, fault_code, pat;
    logic [31:0] pwdata = 32'h0, prdata, q, cfg;
    logic        pready, pslverr, dc_brake_now, fault_strobe, fault_stop, freq_hold, e;
    logic        pid_reverse, panel_stop, pid_int_freeze, main_preset, aux_preset;
    logic        pid_gain_sel, torque_mode, emerg_stop, decel_stop, decel_dc_brake;
    logic        run_time_clear, counting = 1'b0;
    logic [2:0]  fault_action;
    logic [1:0]  cmd_source, motor_sel, accdec_sel, src;
    logic [15:0] mref_value, mref_freq, maxf, refs [16];
    logic [7:0]  mask;
    integer      err_count = 0, total_checks = 0, seed = 32'h5175, i, k, j, pass;
    integer      pc [8];
    integer      codes [9] = '{32, 33, 36, 44, 45, 47, 48, 49, 50};
    wire  [7:0]  pv = {fault_strobe, run_time_clear, decel_dc_brake, decel_stop,
                       emerg_stop, panel_stop, fault_stop, dc_brake_now};

    // ------------------------------------------------------------
    // Clock, design, switches
    // ------------------------------------------------------------
    always #50 clk_sys = ~clk_sys;

    term_decoder u_dut (
        .CLK_SYS(clk_sys), .RST(rst), .TERM_IN(pins), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .DC_BRAKE_NOW(dc_brake_now), .FAULT_STROBE(fault_strobe),
        .FAULT_CODE(fault_code), .FAULT_ACTION(fault_action), .FAULT_STOP(fault_stop),
        .FREQ_HOLD(freq_hold), .PID_REVERSE(pid_reverse), .PANEL_STOP(panel_stop),
        .CMD_SOURCE(cmd_source), .PID_INT_FREEZE(pid_int_freeze), .MAIN_PRESET(main_preset),
        .AUX_PRESET(aux_preset), .MOTOR_SEL(motor_sel), .PID_GAIN_SEL(pid_gain_sel),
        .TORQUE_MODE(torque_mode), .EMERG_STOP(emerg_stop), .DECEL_STOP(decel_stop),
        .DECEL_DC_BRAKE(decel_dc_brake), .RUN_TIME_CLEAR(run_time_clear),
        .MREF_VALUE(mref_value), .MREF_FREQ(mref_freq), .ACCDEC_SEL(accdec_sel));

    term_switches u_sw (.clk(clk_sys), .want(want), .pins(pins));

    // Pulse counter; one sample per edge since each pulse stands one cycle
    always @(posedge clk_sys) begin
        if (counting) for (j = 0; j < 8; j = j + 1) pc[j] = pc[j] + pv[j];
    end

    // ------------------------------------------------------------
    // Expectations and bus tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] exp_mask(input integer c, input logic [31:0] f);
        case (c)
            32: return 8'h01;
            33: return 8'h82;
            36: return (f[4:3] == `SRC_PANEL) ? 8'h04 : 8'h00;
            44, 45: return 8'h80;
            47: return 8'h08;
            48: return 8'h10;
            49: return 8'h20;
            default: return f[5] ? 8'h40 : 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] exp_fault(input integer c);
        return (c == 33) ? `EXT_FAULT_CODE : (c == 44) ? `USER_FAULT1_CODE : `USER_FAULT2_CODE;
    endfunction

    // Scaled reference, clipped at full frequency
    function automatic logic [15:0] exp_freq(input logic [15:0] r, input logic [15:0] m);
        logic [31:0] p;
        p = {16'h0, r} * {16'h0, m} / `REF_FULL_SCALE;
        return (p > {16'h0, m}) ? m : p[15:0];
    endfunction

    task automatic test_done;
        if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wait_n(input integer n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Setup, access held until ready is sampled, then release
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        integer n;
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk_sys); n = n + 1; end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            err_count = err_count + 1;
            test_done;
        end else begin
            q = prdata; e = pslverr; psel <= 1'b0; penable <= 1'b0;
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        wait_n(5);
        rst <= 1'b0;
        apb(1'b0, `OFS_CONFIG, 32'h0);
        `CHK("config reset", `CONFIG_RESET, q)
        `CHK("no error", 1'b0, e)
        apb(1'b0, `OFS_MAX_FREQ, 32'h0);
        `CHK("max freq reset", `MAX_FREQ_RESET, q[15:0])
        `CHK("source after reset", `SRC_TERMINAL, cmd_source)
        apb(1'b0, 8'h30, 32'h0);
        `CHK("unmapped error", 1'b1, e)
        apb(1'b1, `OFS_ACTIVE, 32'hffff);
        `CHK("read-only error", 1'b1, e)
        // Edge functions: on, one low cycle, on again; panel then terminal source
        for (pass = 0; pass < 2; pass = pass + 1) begin
            cfg = pass ? 32'h148 : 32'h20;
            apb(1'b1, `OFS_CONFIG, cfg);
            for (i = 0; i < 9; i = i + 1) begin
                apb(1'b1, `OFS_FUNC_LO, codes[i]);
                for (k = 0; k < 8; k = k + 1) pc[k] = 0;
                mask = exp_mask(codes[i], cfg);
                counting = 1'b1;
                want <= 8'h01;
                wait_n(6);
                if (codes[i] == 48) `CHK("time set on stop", `ACCDEC_SET4, accdec_sel)
                if (mask[7]) `CHK("fault code", exp_fault(codes[i]), fault_code)
                want <= 8'h00;
                wait_n(1);
                want <= 8'h01;
                wait_n(6);
                want <= 8'h00;
                wait_n(6);
                counting = 1'b0;
                for (k = 0; k < 8; k = k + 1) `CHK("pulse count", mask[k] ? 2 : 0, pc[k])
            end
            `CHK("fault action", cfg[8:6], fault_action)
        end
        // Stored references, with exact full scale and an over-range entry
        maxf = $random(seed);
        apb(1'b1, `OFS_MAX_FREQ, {16'h0, maxf});
        for (i = 0; i < 16; i = i + 1) begin
            refs[i] = (i == 15) ? 16'd1000 : (i == 14) ? 16'd1500 : {$random(seed)} % 1100;
            apb(1'b1, 8'(`OFS_REF_BASE + 4 * i), {16'h0, refs[i]});
        end
        apb(1'b1, `OFS_FUNC_LO, 32'h0f0e0d0c);
        apb(1'b1, `OFS_FUNC_HI, 32'h2a291110);
        for (i = 0; i < 24; i = i + 1) begin
            pat = (i == 0) ? 8'hff : $random(seed);
            want <= pat;
            wait_n(6);
            `CHK("reference", refs[pat[3:0]], mref_value)
            `CHK("reference freq", exp_freq(refs[pat[3:0]], maxf), mref_freq)
            `CHK("time set", pat[5:4], accdec_sel)
            `CHK("motor", pat[7:6], motor_sel)
        end
        // Level functions under random configuration
        apb(1'b1, `OFS_FUNC_LO, 32'h27262322);
        apb(1'b1, `OFS_FUNC_HI, 32'h252e2b28);
        for (i = 0; i < 24; i = i + 1) begin
            cfg = $random(seed);
            src = cfg[3] ? `SRC_COMM : `SRC_TERMINAL;
            cfg = {27'h0, src, cfg[2:0]};
            apb(1'b1, `OFS_CONFIG, cfg);
            pat = $random(seed);
            want <= pat;
            wait_n(6);
            `CHK("freq hold", pat[0], freq_hold)
            `CHK("pid reverse", cfg[0] ^ pat[1], pid_reverse)
            `CHK("integral freeze", pat[2], pid_int_freeze)
            `CHK("presets", pat[4:3], {aux_preset, main_preset})
            `CHK("gain set", cfg[1] & pat[5], pid_gain_sel)
            `CHK("torque mode", cfg[2] ^ pat[6], torque_mode)
            `CHK("source", pat[7] ? 2'h3 - src : src, cmd_source)
            apb(1'b0, `OFS_STATUS, 32'h0);
            `CHK("synced terminals", pat, q[7:0])
        end
        test_done;
    end
endmodule // term_decoder_tb
